// ===== design/resize_chroma_mode_config.sv
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "resize_chroma_map.svh"
module resize_chroma_mode_config (
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   input  wire resize_chroma_pkg::addr_t  addr,
   input  wire resize_chroma_pkg::word_t  wdata,
   input  wire logic                      wr_en,
   input  wire logic                      rd_en,
   output resize_chroma_pkg::word_t       rdata,
   input  wire logic                      chroma_convert_on,
   output logic                           horiz_scale_on,
   output resize_chroma_pkg::kernel_e     horiz_kernel,
   output logic                           vert_scale_on,
   output resize_chroma_pkg::kernel_e     vert_kernel,
   output logic                           vert_interp_bypass,
   output logic                           horiz_antialias_active,
   output logic                           aa_manual_active,
   output logic [7:0]                     aa_weight_a,
   output logic [7:0]                     aa_weight_b,
   output logic [11:0]                    horiz_divisor,
   output logic [11:0]                    vert_divisor,
   output logic                           divisor_error,
   output logic [8:0]                     horiz_phase,
   output logic [9:0]                     vert_phase,
   output logic                           chroma_src_mpeg1,
   output logic                           chroma_res_mpeg1,
   output resize_chroma_pkg::kernel_e     chroma_horiz_kernel,
   output logic                           chroma_horiz_kernel_active,
   output resize_chroma_pkg::kernel_e     chroma_vert_kernel
);
   import resize_chroma_pkg::*;

   // ****************************************
   // registers
   // ****************************************
   logic [31:0] resize_mode_r;
   logic [11:0] horiz_scale_divisor_r;
   logic [11:0] vert_scale_divisor_r;
   logic [8:0]  horiz_start_phase_r;
   logic [9:0]  vert_start_phase_r;
   logic [7:0]  antialias_strength_r;
   logic [3:0]  chroma_mode_r;
   word_t       rdata_r;
   word_t       rdata_nxt;

   wire logic wr_mode   = wr_en && (addr == `RC_OFS_RESIZE_MODE);
   wire logic wr_hdiv   = wr_en && (addr == `RC_OFS_HORIZ_RATIO);
   wire logic wr_vdiv   = wr_en && (addr == `RC_OFS_VERT_RATIO);
   wire logic wr_hph    = wr_en && (addr == `RC_OFS_HORIZ_PHASE);
   wire logic wr_vph    = wr_en && (addr == `RC_OFS_VERT_PHASE);
   wire logic wr_aa     = wr_en && (addr == `RC_OFS_AA_INTENSITY);
   wire logic wr_chroma = wr_en && (addr == `RC_OFS_CHROMA_MODE);

   // reserved bits masked at write so they never reach the datapath
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         resize_mode_r         <= `RC_RESET_VALUE;                                   // see (R21)
         horiz_scale_divisor_r <= 12'h000;
         vert_scale_divisor_r  <= 12'h000;
         horiz_start_phase_r   <= 9'h000;
         vert_start_phase_r    <= 10'h000;
         antialias_strength_r  <= 8'h00;
         chroma_mode_r         <= 4'h0;
      end else begin
         if (wr_mode)   resize_mode_r <= wdata & `RC_MODE_MASK;                       // see (R20)
         if (wr_hdiv)   horiz_scale_divisor_r <= wdata[11:0];
         if (wr_vdiv)   vert_scale_divisor_r <= wdata[11:0];
         if (wr_hph)    horiz_start_phase_r <= wdata[8:0];
         if (wr_vph)    vert_start_phase_r <= wdata[9:0];
         if (wr_aa)     antialias_strength_r <= wdata[7:0];
         if (wr_chroma) chroma_mode_r <= wdata[3:0];
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_comb begin
      case (addr)
         `RC_OFS_RESIZE_MODE:  rdata_nxt = resize_mode_r;
         `RC_OFS_HORIZ_RATIO:  rdata_nxt = {20'h00000, horiz_scale_divisor_r};
         `RC_OFS_VERT_RATIO:   rdata_nxt = {20'h00000, vert_scale_divisor_r};
         `RC_OFS_HORIZ_PHASE:  rdata_nxt = {23'h000000, horiz_start_phase_r};
         `RC_OFS_VERT_PHASE:   rdata_nxt = {22'h000000, vert_start_phase_r};
         `RC_OFS_AA_INTENSITY: rdata_nxt = {24'h000000, antialias_strength_r};
         `RC_OFS_CHROMA_MODE:  rdata_nxt = {28'h0000000, chroma_mode_r};
         default:              rdata_nxt = 32'h0000_0000;                            // see (R20)
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) rdata_r <= 32'h0000_0000;
      else if (rd_en) rdata_r <= rdata_nxt;
      else rdata_r <= 32'h0000_0000;
   end
   assign rdata = rdata_r;

   // ****************************************
   // decoded controls
   // ****************************************
   wire logic h_aa_on  = resize_mode_r[`RC_BIT_H_AA_ON];
   wire logic h_manual = resize_mode_r[`RC_BIT_H_AA_MANUAL];
   logic [7:0] wa;
   logic [7:0] wb;

   aa_weight_calc aa_weight_calc_i (
      .strength (antialias_strength_r),
      .weight_a (wa),
      .weight_b (wb)
   );

   assign horiz_scale_on = resize_mode_r[`RC_BIT_H_ON];                              // see (R7)
   assign horiz_kernel   = (horiz_scale_on && resize_mode_r[`RC_BIT_H_KERNEL])
                           ? KERNEL_LINEAR : KERNEL_CUBIC;                           // see (R6)
   assign vert_scale_on  = resize_mode_r[`RC_BIT_V_ON];                              // see (R5)
   assign vert_kernel    = (vert_scale_on && resize_mode_r[`RC_BIT_V_KERNEL])
                           ? KERNEL_LINEAR : KERNEL_CUBIC;                           // see (R4)
   assign vert_interp_bypass     = resize_mode_r[`RC_BIT_V_AA_ON];                   // see (R1)
   assign horiz_antialias_active = h_aa_on;                                          // see (R3)
   assign aa_manual_active       = h_aa_on && h_manual;                              // see (R2)
   // zero weights when unused: automatic weights come from the datapath
   assign aa_weight_a = aa_manual_active ? wa : 8'h00;                               // see (R13)
   assign aa_weight_b = aa_manual_active ? wb : 8'h00;                               // see (R13)
   assign horiz_divisor = horiz_scale_divisor_r;                                     // see (R8)
   assign vert_divisor  = vert_scale_divisor_r;                                      // see (R9)
   // flags a bad ratio only for an enabled direction; no clamping applied
   assign divisor_error = (horiz_scale_on && (horiz_scale_divisor_r < `RC_DIV_MIN
                            || horiz_scale_divisor_r > `RC_DIV_MAX))
                        || (vert_scale_on && (vert_scale_divisor_r < `RC_DIV_MIN
                            || vert_scale_divisor_r > `RC_DIV_MAX));                 // see (R8) (R9)
   assign horiz_phase = horiz_start_phase_r;                                         // see (R10)
   assign vert_phase  = vert_start_phase_r;                                          // see (R11)
   assign chroma_src_mpeg1 = chroma_convert_on && chroma_mode_r[`RC_BIT_C_SRC];      // see (R17) (R19)
   assign chroma_res_mpeg1 = chroma_convert_on && chroma_mode_r[`RC_BIT_C_RES];      // see (R18)
   assign chroma_horiz_kernel_active = (chroma_mode_r[1:0] == 2'h1)
                                    || (chroma_mode_r[1:0] == 2'h2);                 // see (R15)
   assign chroma_horiz_kernel = (chroma_horiz_kernel_active && chroma_mode_r[`RC_BIT_C_HKERNEL])
                                ? KERNEL_LINEAR : KERNEL_CUBIC;                      // see (R15)
   assign chroma_vert_kernel = chroma_mode_r[`RC_BIT_C_VKERNEL]
                               ? KERNEL_LINEAR : KERNEL_CUBIC;                       // see (R16)

   // ****************************************
   // checks
   // ****************************************
   a_mode_write_seen: assert property (@(posedge clock) disable iff (!rst_n)   // see (R20)
      wr_mode |=> resize_mode_r == ($past(wdata) & `RC_MODE_MASK))
      else $error("mode write not stored");
   a_read_next_cycle: assert property (@(posedge clock) disable iff (!rst_n)   // see (R20)
      rd_en && addr == `RC_OFS_AA_INTENSITY && !wr_en |=> rdata[31:8] == 24'h0)
      else $error("reserved bits not zero");
   a_weight_a_clip: assert property (@(posedge clock) disable iff (!rst_n)     // see (R14)
      aa_manual_active |-> aa_weight_a <= 8'h40 && aa_weight_b >= 8'h40 && aa_weight_b <= 8'h80)
      else $error("weight out of range");
   a_weight_gated: assert property (@(posedge clock) disable iff (!rst_n)      // see (R13)
      !aa_manual_active |-> aa_weight_a == 8'h00 && aa_weight_b == 8'h00)
      else $error("weights used while not manual");
   a_strength_clip: assert property (@(posedge clock) disable iff (!rst_n)     // see (R12)
      aa_manual_active && antialias_strength_r > 8'h80 |-> aa_weight_b == 8'h80)
      else $error("strength not clipped");
   a_vkernel_gate: assert property (@(posedge clock) disable iff (!rst_n)      // see (R4)
      !vert_scale_on |-> vert_kernel == KERNEL_CUBIC)
      else $error("vertical kernel ungated");
   a_hkernel_gate: assert property (@(posedge clock) disable iff (!rst_n)      // see (R6)
      !horiz_scale_on |-> horiz_kernel == KERNEL_CUBIC)
      else $error("horizontal kernel ungated");
   a_codec_gate: assert property (@(posedge clock) disable iff (!rst_n)        // see (R17)
      !chroma_convert_on |-> !chroma_src_mpeg1 && !chroma_res_mpeg1)
      else $error("codec bits honoured while off");
   a_chroma_hgate: assert property (@(posedge clock) disable iff (!rst_n)      // see (R15)
      chroma_mode_r[1:0] == 2'h3 |-> chroma_horiz_kernel == KERNEL_CUBIC)
      else $error("chroma horizontal kernel ungated");
   a_reset_zero: assert property (@(posedge clock)                            // see (R21)
      !rst_n |=> resize_mode_r == 32'h0 && chroma_mode_r == 4'h0 && rdata == 32'h0)
      else $error("reset value not zero");

   c_manual_aa:   cover property (@(posedge clock) disable iff (!rst_n) aa_manual_active);
   c_both_scale:  cover property (@(posedge clock) disable iff (!rst_n) horiz_scale_on && vert_scale_on);
   c_bad_ratio:   cover property (@(posedge clock) disable iff (!rst_n) divisor_error);
   c_mpeg1_src:   cover property (@(posedge clock) disable iff (!rst_n) chroma_src_mpeg1);
endmodule // resize_chroma_mode_config

// ===== include/resize_chroma_map.svh
// Function
// (R1) vertical antialias bit: bypass vertical interpolation, downsample
// (R2) manual select: auto weights 0, manual 1
// (R3) horizontal antialias enable activates filter
// (R4) vertical kernel: cubic 0, linear 1
// (R5) vertical scale enable, needs vertical divisor
// (R6) horizontal kernel: cubic 0, linear 1
// (R7) horizontal scale enable, needs horizontal divisor
// (R8) horizontal divisor 256..2048, ratio 256/value
// (R9) vertical divisor 256..2048, ratio 256/value
// (R10) horizontal start phase is value/512 pixel
// (R11) vertical start phase is value/1024 line
// (R12) strength above 128 clipped to 128
// (R13) strength used only manual and enabled
// (R14) weight a clip 0..64, b 64..128
// (R15) chroma horizontal kernel acts only codec 1/2
// (R16) chroma vertical kernel: cubic 0, linear 1
// (R17) source codec honoured only with conversion on
// (R18) result codec: 0 others, 1 MPEG-1, gated
// (R19) source codec: 0 others, 1 MPEG-1
// (R20) reserved bits read zero, writes ignored
// (R21) all fields reset to zero
`ifndef RESIZE_CHROMA_MAP_SVH
`define RESIZE_CHROMA_MAP_SVH
// ****************************************
// offsets
// ****************************************
`define RC_OFS_RESIZE_MODE   8'h00
`define RC_OFS_HORIZ_RATIO   8'h04
`define RC_OFS_VERT_RATIO    8'h08
`define RC_OFS_HORIZ_PHASE   8'h0C
`define RC_OFS_VERT_PHASE    8'h10
`define RC_OFS_AA_INTENSITY  8'h14
`define RC_OFS_CHROMA_MODE   8'h18
// ****************************************
// fields
// ****************************************
`define RC_BIT_H_ON          0
`define RC_BIT_H_KERNEL      1
`define RC_BIT_V_ON          4
`define RC_BIT_V_KERNEL      5
`define RC_BIT_H_AA_ON       8
`define RC_BIT_H_AA_MANUAL   9
`define RC_BIT_V_AA_ON       12
`define RC_BIT_C_RES         0
`define RC_BIT_C_SRC         1
`define RC_BIT_C_VKERNEL     2
`define RC_BIT_C_HKERNEL     3
`define RC_MODE_MASK         32'h0000_1333
`define RC_CHROMA_MASK       32'h0000_000F
`define RC_DIV_MIN           12'h100
`define RC_DIV_MAX           12'h800
`define RC_AA_MAX            8'h80
`define RC_AA_MID            8'h40
`define RC_RESET_VALUE       32'h0000_0000
`endif

// ===== include/resize_chroma_pkg.sv
package resize_chroma_pkg;
   typedef logic [7:0]  addr_t;
   typedef logic [31:0] word_t;
   typedef enum logic [1:0] {KERNEL_CUBIC = 2'h1, KERNEL_LINEAR = 2'h2} kernel_e;
endpackage

// ===== design/aa_weight_calc.sv
`timescale 1ns/1ps
`include "resize_chroma_map.svh"
module aa_weight_calc (
   input  wire logic [7:0] strength,
   output logic      [7:0] weight_a,
   output logic      [7:0] weight_b
);
   wire logic [7:0] clipped;
   assign clipped  = (strength > `RC_AA_MAX) ? `RC_AA_MAX : strength;                // see (R12)
   assign weight_a = (clipped > `RC_AA_MID) ? `RC_AA_MID : clipped;                  // see (R14)
   assign weight_b = (clipped < `RC_AA_MID) ? `RC_AA_MID : clipped;                  // see (R14)
endmodule // aa_weight_calc

// ===== verification/test_resize_chroma_mode_config.sv
`timescale 1ns/1ps
`include "resize_chroma_map.svh"
module test_resize_chroma_mode_config;
   import resize_chroma_pkg::*;
   logic        clock, rst_n, wr_en, rd_en, cc_on;
   addr_t       addr;
   word_t       wdata, rdata;
   logic        h_on, v_on, bypass, aa_on, aa_man, d_err, c_src, c_res, c_hact;
   kernel_e     h_k, v_k, c_hk, c_vk;
   logic [7:0]  wa, wb;
   logic [11:0] h_div, v_div;
   logic [8:0]  h_ph;
   logic [9:0]  v_ph;
   int          err_total, n_checks;
   // ****************************************
   // expectation tables
   // ****************************************
   logic [7:0]  aa_in [4] = '{8'hFF, 8'h30, 8'h50, 8'h80};
   logic [7:0]  aa_a [4]  = '{8'h40, 8'h30, 8'h40, 8'h40};
   logic [7:0]  aa_b [4]  = '{8'h80, 8'h40, 8'h50, 8'h80};
   logic [11:0] dv [4]    = '{12'h0FF, 12'h100, 12'h800, 12'h801};
   logic        dv_bad [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   logic [3:0]  cm [3]    = '{4'h9, 4'h6, 4'hC};
   resize_chroma_mode_config resize_chroma_mode_config_i (
      .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .chroma_convert_on(cc_on), .horiz_scale_on(h_on), .horiz_kernel(h_k),
      .vert_scale_on(v_on), .vert_kernel(v_k), .vert_interp_bypass(bypass),
      .horiz_antialias_active(aa_on), .aa_manual_active(aa_man), .aa_weight_a(wa), .aa_weight_b(wb),
      .horiz_divisor(h_div), .vert_divisor(v_div), .divisor_error(d_err), .horiz_phase(h_ph),
      .vert_phase(v_ph), .chroma_src_mpeg1(c_src), .chroma_res_mpeg1(c_res),
      .chroma_horiz_kernel(c_hk), .chroma_horiz_kernel_active(c_hact), .chroma_vert_kernel(c_vk));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cmp_word(input word_t got, input word_t exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_out(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: output %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input addr_t a, input word_t d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      @(negedge clock);
   endtask
   // read data only in the cycle after the strobe, zero after
   task automatic rd(input addr_t a, input word_t exp);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(negedge clock);
      cmp_word(rdata, exp);
      @(negedge clock);
      cmp_word(rdata, 32'h0000_0000);
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (2000) @(posedge clock);
      err_total++;
      complete_run();
   end
   initial begin
      rst_n = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      cc_on = 1'b0;
      err_total = 0;
      n_checks = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0000_0000);
      cmp_out(h_k, KERNEL_CUBIC);
      wr(`RC_OFS_RESIZE_MODE, 32'hFFFF_FFFF);
      rd(`RC_OFS_RESIZE_MODE, 32'h0000_1333);
      cmp_out(h_on, 12'h001);
      cmp_out(v_on, 12'h001);
      cmp_out(h_k, KERNEL_LINEAR);
      cmp_out(v_k, KERNEL_LINEAR);
      cmp_out({bypass, aa_on, aa_man}, 12'h007);
      // kernel and manual bits set with their enables off
      wr(`RC_OFS_RESIZE_MODE, 32'h0000_0222);
      cmp_out({h_k, v_k}, {KERNEL_CUBIC, KERNEL_CUBIC});
      cmp_out({h_on, v_on, bypass, aa_on, aa_man}, 12'h000);
      wr(`RC_OFS_RESIZE_MODE, 32'h0000_0300);
      for (int i = 0; i < 4; i++) begin
         wr(`RC_OFS_AA_INTENSITY, {24'hFFFFFF, aa_in[i]});
         cmp_out({wa, 4'h0}, {aa_a[i], 4'h0});
         cmp_out({wb, 4'h0}, {aa_b[i], 4'h0});
      end
      wr(`RC_OFS_AA_INTENSITY, 32'hFFFF_FFFF);
      rd(`RC_OFS_AA_INTENSITY, 32'h0000_00FF);
      wr(`RC_OFS_RESIZE_MODE, 32'h0000_0100);
      cmp_out({aa_man, wa}, 12'h000);
      cmp_out({4'h0, wb}, 12'h000);
      wr(`RC_OFS_RESIZE_MODE, 32'h0000_0011);
      for (int i = 0; i < 4; i++) begin
         wr(`RC_OFS_HORIZ_RATIO, {20'hFFFFF, dv[i]});
         wr(`RC_OFS_VERT_RATIO, {20'hFFFFF, dv[i]});
         cmp_out(h_div, dv[i]);
         cmp_out(v_div, dv[i]);
         cmp_out(d_err, dv_bad[i]);
      end
      rd(`RC_OFS_VERT_RATIO, 32'h0000_0801);
      wr(`RC_OFS_RESIZE_MODE, 32'h0000_0000);
      cmp_out(d_err, 12'h000);
      wr(`RC_OFS_HORIZ_PHASE, 32'hFFFF_FFFF);
      wr(`RC_OFS_VERT_PHASE, 32'hFFFF_FFFF);
      rd(`RC_OFS_HORIZ_PHASE, 32'h0000_01FF);
      rd(`RC_OFS_VERT_PHASE, 32'h0000_03FF);
      cmp_out({h_ph, 3'h0}, {9'h1FF, 3'h0});
      cmp_out({v_ph, 2'h0}, {10'h3FF, 2'h0});
      wr(`RC_OFS_CHROMA_MODE, 32'hFFFF_FFFF);
      rd(`RC_OFS_CHROMA_MODE, 32'h0000_000F);
      cmp_out({c_src, c_res, c_hact}, 12'h000);
      // codec bits 3: horizontal kernel bit must stay without effect
      cmp_out(c_hk, KERNEL_CUBIC);
      cmp_out(c_vk, KERNEL_LINEAR);
      @(posedge clock);
      cc_on <= 1'b1;
      @(negedge clock);
      cmp_out({c_src, c_res}, 12'h003);
      for (int i = 0; i < 3; i++) begin
         wr(`RC_OFS_CHROMA_MODE, {28'h0, cm[i]});
         cmp_out(c_hact, (cm[i][1:0] == 2'h1 || cm[i][1:0] == 2'h2));
         cmp_out(c_hk, (cm[i][3] && (cm[i][1:0] == 2'h1 || cm[i][1:0] == 2'h2))
                       ? KERNEL_LINEAR : KERNEL_CUBIC);
         cmp_out(c_vk, cm[i][2] ? KERNEL_LINEAR : KERNEL_CUBIC);
         cmp_out({c_src, c_res}, {10'h0, cm[i][1:0]});
      end
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C, 32'h0000_0000);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd(`RC_OFS_CHROMA_MODE, 32'h0000_0000);
      rd(`RC_OFS_HORIZ_RATIO, 32'h0000_0000);
      rd(`RC_OFS_AA_INTENSITY, 32'h0000_0000);
      complete_run();
   end
endmodule // test_resize_chroma_mode_config
